// file: hdl/ssd_pkg.sv
// Constants shared by the stepper serial control and diagnosis block.
// Assumes a single 20 MHz system clock domain and classic Wishbone.
package ssd_pkg;

  // ---------------------------------------------------------------
  // Command and reply byte layout
  // ---------------------------------------------------------------
  localparam int          CMD_W        = 8;
  localparam int          BIT_ERR1     = 7;
  localparam int          BIT_ERR2     = 6;
  localparam int          BIT_A_POL    = 3;
  localparam int          BIT_B_POL    = 0;
  localparam int          N_BRIDGE     = 2;
  localparam logic [1:0]  CUR_OFF      = 2'h3;
  localparam logic [1:0]  CUR_HOLD     = 2'h2;
  localparam logic [7:0]  CMD_RST      = 8'h3f;
  localparam logic [1:0]  FC_NORMAL    = 2'h3;
  localparam logic [1:0]  FC_SINK      = 2'h1;
  localparam logic [1:0]  FC_SOURCE    = 2'h2;
  localparam logic [1:0]  FC_OVERTEMP  = 2'h0;

  // ---------------------------------------------------------------
  // Serial framing and diagnosis filter
  // ---------------------------------------------------------------
  localparam int          FRAME_MOD      = 8;
  localparam int          FCNT_W         = 3;
  localparam int          SETTLE_SAMPLES = 4;

  // ---------------------------------------------------------------
  // Pin synchroniser slots and their idle levels
  // ---------------------------------------------------------------
  localparam int          PIN_SDI = 0;
  localparam int          PIN_SCK = 1;
  localparam int          PIN_CSN = 2;
  localparam int          PIN_ENN = 3;
  localparam int          N_PIN   = 4;
  localparam logic [3:0]  PIN_RST = 4'hc;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int          WB_ADR_W      = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_CMD       = 8'h08;
  localparam int          CTRL_DIAG_EN  = 0;
  localparam logic        CTRL_DIAG_RST = 1'h1;
  localparam int          ST_SETTLED    = 8;
  localparam int          ST_SHORT_VS   = 10;
  localparam int          ST_OVERLOAD   = 12;
  localparam int          ST_OPEN       = 13;
  localparam int          CMD_DISC_LSB  = 8;
  localparam int          DISC_W        = 8;

endpackage

// file: hdl/ssd_filter.sv
// Settling filter for one bridge's missing-flyback indication.
// Assumes sample and raw_fault are single-cycle signals on clk.
`timescale 1ns/100ps
module ssd_filter
  import ssd_pkg::*;
#(
  parameter int SETTLE = SETTLE_SAMPLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic clear,
  input  wire logic sample,
  input  wire logic raw_fault,
  // Result
  output logic      fault,
  output logic      settled
);

  localparam int             CW   = $clog2(SETTLE + 1);
  localparam logic [CW-1:0]  FULL = CW'(SETTLE);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (SETTLE < 2) begin : g_bad
    $error("ssd_filter: SETTLE must be at least 2");
  end

  logic [SETTLE-1:0] hist;
  logic [SETTLE-1:0] next_hist;
  logic [CW-1:0]     cnt;
  logic [CW-1:0]     next_cnt;

  // History starts as all faults, so an early reply may show open load
  always_comb begin
    next_hist = hist;
    next_cnt  = cnt;
    if (clear) begin
      next_hist = '1;
      next_cnt  = '0;
    end else if (sample) begin
      next_hist = {hist[SETTLE-2:0], raw_fault};
      if (cnt != FULL) begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= '1;
      cnt  <= '0;
    end else begin
      hist <= next_hist;
      cnt  <= next_cnt;
    end
  end

  // A lone noisy sample cannot raise the fault
  assign fault   = &hist;
  assign settled = (cnt == FULL);

endmodule

// file: hdl/ssd_top.sv
// Serial command port and fault diagnosis of a two-bridge stepper
// driver, with a Wishbone slave for control and observation.
// Assumes pins arrive asynchronously and sensor events are on CLK.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Fault filter settles after four samples
// - Without chopping, sample on each polarity change
// - Early replies may show open load
// - Comparator trip rewrites short-to-supply flag
// - Short flag holds until reset, deactivation or next trip
// - Hold current blanks flyback check on reversal
// - Hold current keeps flyback check during PWM
// - Code 11 normal, 01 sink or flyback fault
// - Source overload gives code 10, masks open
// - Over-temperature pre-alarm gives code 00
// - Activation falling edge wakes the device
// - Frame select falling edge starts a frame
// - Sample serial input on clock rising edge
// - Shift serial output on clock falling edge
// - Accept only multiple-of-eight falling edges
// - Bad count discards data, bridges unchanged
// - Serial output driven only during frame select
// - Decode currents and polarities, encode fault bits
// - Both current bits high switches bridge off
// - Frame end clears overload, re-enables bridge
module ssd_top
  import ssd_pkg::*;
#(
  parameter int SETTLE = SETTLE_SAMPLES
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RSTN,
  // Serial port pins
  input  wire logic                DEVICE_ACTIVATE_N,
  input  wire logic                FRAME_SELECT_N,
  input  wire logic                SCK,
  input  wire logic                SDI,
  output logic                     SDO,
  output logic                     SDO_OE,
  // Bridge sensor events, index 0 is bridge A
  input  wire logic [1:0]          CHOP_PULSE,
  input  wire logic [1:0]          CMP_TRIP,
  input  wire logic [1:0]          SHORT_DET,
  input  wire logic [1:0]          NO_FLYBACK,
  input  wire logic                SRC_OVL,
  input  wire logic                OVERTEMP,
  // Bridge settings
  output logic [CMD_W-1:0]         BRIDGE_CMD,
  output logic [1:0]               DRIVERS_OFF,
  // Wishbone slave
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  input  wire logic                WB_WE_I,
  input  wire logic [WB_ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]          WB_SEL_I,
  input  wire logic [31:0]         WB_DAT_I,
  output logic [31:0]              WB_DAT_O,
  output logic                     WB_ACK_O
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [N_PIN-1:0] pin_in;
  logic [N_PIN-1:0] sync1;
  logic [N_PIN-1:0] sync2;
  logic [N_PIN-1:0] sync3;
  logic [N_PIN-1:0] pin;
  logic [N_PIN-1:0] next_pin;

  assign pin_in = {DEVICE_ACTIVATE_N, FRAME_SELECT_N, SCK, SDI};

  // A level counts once the second and third stages agree
  always_comb begin
    next_pin = pin;
    for (int i = 0; i < N_PIN; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_pin[i] = sync2[i];
      end
    end
  end

  // Three stages; only sync2 reads sync1
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= PIN_RST;
      sync2 <= PIN_RST;
      sync3 <= PIN_RST;
      pin   <= PIN_RST;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= next_pin;
    end
  end

  // Edges of the filtered levels
  logic deact;
  logic csn_fall;
  logic csn_rise;
  logic sck_rise;
  logic sck_fall;
  logic in_frame;

  assign deact    = pin[PIN_ENN] | next_pin[PIN_ENN];
  assign csn_fall = pin[PIN_CSN] & ~next_pin[PIN_CSN];
  assign csn_rise = ~pin[PIN_CSN] & next_pin[PIN_CSN];
  assign in_frame = ~pin[PIN_CSN] & ~next_pin[PIN_CSN];
  assign sck_rise = ~pin[PIN_SCK] & next_pin[PIN_SCK];
  assign sck_fall = pin[PIN_SCK] & ~next_pin[PIN_SCK];

  // ---------------------------------------------------------------
  // Serial shift engine and command latch
  // ---------------------------------------------------------------
  logic [CMD_W-1:0]  shreg;
  logic [CMD_W-1:0]  next_shreg;
  logic              sdi_bit;
  logic              next_sdi_bit;
  logic [FCNT_W-1:0] fall_cnt;
  logic [FCNT_W-1:0] next_fall_cnt;
  logic              any_fall;
  logic              next_any_fall;
  logic [CMD_W-1:0]  cmd;
  logic [CMD_W-1:0]  next_cmd;
  logic [1:0]        reply_code;
  logic [1:0]        next_reply_code;
  logic [DISC_W-1:0] disc_cnt;
  logic [DISC_W-1:0] next_disc_cnt;
  logic [1:0]        fault_code;
  logic              accept;
  logic [1:0]        pol_chg;

  // A frame is taken only on whole bytes, so cascades keep the last one
  assign accept = ~deact & csn_rise & any_fall
                & (fall_cnt == '0);
  assign pol_chg[0] = accept & (shreg[BIT_A_POL] ^ cmd[BIT_A_POL]);
  assign pol_chg[1] = accept & (shreg[BIT_B_POL] ^ cmd[BIT_B_POL]);

  // Shift, count and latch
  always_comb begin
    next_shreg      = shreg;
    next_sdi_bit    = sdi_bit;
    next_fall_cnt   = fall_cnt;
    next_any_fall   = any_fall;
    next_cmd        = cmd;
    next_reply_code = reply_code;
    next_disc_cnt   = disc_cnt;
    if (deact) begin
      next_shreg      = '1;
      next_sdi_bit    = 1'b0;
      next_fall_cnt   = '0;
      next_any_fall   = 1'b0;
      next_cmd        = CMD_RST;
      next_reply_code = FC_NORMAL;
    end else if (csn_fall) begin
      // Reply carries last frame's code and the applied settings
      next_shreg    = {reply_code, cmd[BIT_ERR2-1:0]};
      next_fall_cnt = '0;
      next_any_fall = 1'b0;
    end else if (in_frame) begin
      if (sck_rise) begin
        next_sdi_bit = pin[PIN_SDI] | next_pin[PIN_SDI]
                     & pin[PIN_SDI];
      end
      if (sck_fall) begin
        next_shreg    = {shreg[CMD_W-2:0], sdi_bit};
        next_fall_cnt = fall_cnt + FCNT_W'(1);
        next_any_fall = 1'b1;
      end
    end else if (csn_rise) begin
      next_reply_code = fault_code;
      if (accept) begin
        next_cmd = shreg;
      end else begin
        next_disc_cnt = disc_cnt + DISC_W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      shreg      <= '1;
      sdi_bit    <= 1'b0;
      fall_cnt   <= '0;
      any_fall   <= 1'b0;
      cmd        <= CMD_RST;
      reply_code <= FC_NORMAL;
      disc_cnt   <= '0;
    end else begin
      shreg      <= next_shreg;
      sdi_bit    <= next_sdi_bit;
      fall_cnt   <= next_fall_cnt;
      any_fall   <= next_any_fall;
      cmd        <= next_cmd;
      reply_code <= next_reply_code;
      disc_cnt   <= next_disc_cnt;
    end
  end

  // Output only while selected; the bench resolves the wire
  assign SDO        = shreg[CMD_W-1];
  assign SDO_OE     = ~pin[PIN_CSN] & ~pin[PIN_ENN];
  assign BRIDGE_CMD = cmd;

  // ---------------------------------------------------------------
  // Per-bridge diagnosis
  // ---------------------------------------------------------------
  logic [1:0] short_vs;
  logic [1:0] open_flt;
  logic [1:0] settled;
  logic [1:0] cur_off;
  logic       diag_en;

  for (genvar b = 0; b < N_BRIDGE; b++) begin : g_bridge
    localparam int PB = (b == 0) ? BIT_A_POL : BIT_B_POL;
    logic       chop_seen;
    logic       next_chop_seen;
    logic       next_short;
    logic       sample;
    logic       raw_open;
    logic       blank;
    logic       short_q;
    logic [1:0] new_cur;

    assign new_cur    = accept ? shreg[PB+2:PB+1] : cmd[PB+2:PB+1];
    assign cur_off[b] = (cmd[PB+2:PB+1] == CUR_OFF);
    // Reversal samples only if no chopping since the last one
    assign sample = CHOP_PULSE[b] | (pol_chg[b] & ~chop_seen);
    // Weak flyback at hold current after reversal is ignored
    assign blank  = pol_chg[b] & ~CHOP_PULSE[b]
                  & (new_cur == CUR_HOLD);
    assign raw_open = NO_FLYBACK[b] & ~blank;

    // Chopping memory and short-to-supply flag
    always_comb begin
      next_chop_seen = chop_seen;
      next_short     = short_q;
      if (deact) begin
        next_chop_seen = 1'b0;
        next_short     = 1'b0;
      end else begin
        if (pol_chg[b]) begin
          next_chop_seen = 1'b0;
        end
        if (CHOP_PULSE[b]) begin
          next_chop_seen = 1'b1;
        end
        if (CMP_TRIP[b]) begin
          next_short = SHORT_DET[b];
        end
      end
    end

    // Registers
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        chop_seen <= 1'b0;
        short_q   <= 1'b0;
      end else begin
        chop_seen <= next_chop_seen;
        short_q   <= next_short;
      end
    end

    assign short_vs[b] = short_q;

    ssd_filter #(
      .SETTLE    (SETTLE)
    ) u_filter (
      .clk       (CLK),
      .rst_n     (RSTN),
      .clear     (deact),
      .sample    (sample),
      .raw_fault (raw_open),
      .fault     (open_flt[b]),
      .settled   (settled[b])
    );
  end

  // ---------------------------------------------------------------
  // Shared overload latch and fault encoding
  // ---------------------------------------------------------------
  logic       ovl;
  logic       next_ovl;
  logic [1:0] drv_off;
  logic [1:0] next_drv_off;

  // A new overload in the closing cycle of a frame still sticks
  always_comb begin
    next_ovl = ovl;
    if (deact) begin
      next_ovl = 1'b0;
    end else if (SRC_OVL) begin
      next_ovl = 1'b1;
    end else if (csn_rise) begin
      next_ovl = 1'b0;
    end
    next_drv_off = cur_off | {N_BRIDGE{ovl}};
  end

  // Registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ovl     <= 1'b0;
      drv_off <= '1;
    end else begin
      ovl     <= next_ovl;
      drv_off <= next_drv_off;
    end
  end

  assign DRIVERS_OFF = drv_off;

  // Dominance: temperature, then source overload, then sink faults
  always_comb begin
    if (!diag_en) begin
      fault_code = FC_NORMAL;
    end else if (OVERTEMP) begin
      fault_code = FC_OVERTEMP;
    end else if (ovl) begin
      fault_code = FC_SOURCE;
    end else if (|short_vs || |open_flt) begin
      fault_code = FC_SINK;
    end else begin
      fault_code = FC_NORMAL;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        next_diag_en;
  logic        req;

  assign req = WB_CYC_I & WB_STB_I;

  // One wait state; unmapped reads return zero, writes are dropped
  always_comb begin
    next_ack     = req & ~ack;
    next_rdata   = '0;
    next_diag_en = diag_en;
    if (req && ack && WB_WE_I && WB_SEL_I[0]
        && WB_ADR_I[WB_ADR_W-1:2] == REG_CTRL[WB_ADR_W-1:2]) begin
      next_diag_en = WB_DAT_I[CTRL_DIAG_EN];
    end
    if (next_ack && !WB_WE_I) begin
      case (WB_ADR_I[WB_ADR_W-1:2])
        REG_CTRL[WB_ADR_W-1:2]: begin
          next_rdata[CTRL_DIAG_EN] = diag_en;
        end
        REG_STATUS[WB_ADR_W-1:2]: begin
          next_rdata[CMD_W-1:0]               = shreg;
          next_rdata[ST_SETTLED+1:ST_SETTLED] = settled;
          next_rdata[ST_SHORT_VS+1:ST_SHORT_VS] = short_vs;
          next_rdata[ST_OVERLOAD]             = ovl;
          next_rdata[ST_OPEN+1:ST_OPEN]       = open_flt;
        end
        REG_CMD[WB_ADR_W-1:2]: begin
          next_rdata[CMD_W-1:0] = cmd;
          next_rdata[CMD_DISC_LSB+DISC_W-1:CMD_DISC_LSB] = disc_cnt;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack     <= 1'b0;
      rdata   <= '0;
      diag_en <= CTRL_DIAG_RST;
    end else begin
      ack     <= next_ack;
      rdata   <= next_rdata;
      diag_en <= next_diag_en;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdata;

endmodule

// file: test/ssd_top_asserts.sv
// Checker on the ports of the stepper serial and diagnosis block.
// Assumes pins are seen 3-4 CLK edges after they change.
`timescale 1ns/100ps
module ssd_chk
  import ssd_pkg::*;
#(
  parameter int SETTLE = SETTLE_SAMPLES
) (
  // Clock and reset
  input wire logic             CLK,
  input wire logic             RSTN,
  // Serial pins
  input wire logic             DEVICE_ACTIVATE_N,
  input wire logic             FRAME_SELECT_N,
  input wire logic             SCK,
  input wire logic             SDO,
  input wire logic             SDO_OE,
  // Bridge settings
  input wire logic [CMD_W-1:0] BRIDGE_CMD,
  input wire logic [1:0]       DRIVERS_OFF,
  // Wishbone
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_ACK_O
);
  // ------------------------------------------------------------
  // Properties; windows allow for the pin synchronisers
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_idle_clears_cmd: assert property (DEVICE_ACTIVATE_N [*8] |->
    BRIDGE_CMD == CMD_RST) else $error("command not cleared when idle");
  a_sdo_released: assert property (FRAME_SELECT_N [*7] |->
    !SDO_OE) else $error("serial output driven outside a frame");
  a_sdo_driven: assert property (!(FRAME_SELECT_N | DEVICE_ACTIVATE_N)
    [*8] |-> SDO_OE) else $error("serial output not driven in frame");
  a_sdo_rise_hold: assert property ((SCK && !FRAME_SELECT_N) [*4]
    |=> $stable(SDO)) else $error("serial output moved on clock high");
  a_cmd_frame_hold: assert property (!(FRAME_SELECT_N |
    DEVICE_ACTIVATE_N) [*8] |=> $stable(BRIDGE_CMD))
    else $error("command changed inside a frame");
  a_cmd_idle_hold: assert property ((FRAME_SELECT_N &&
    !DEVICE_ACTIVATE_N) [*8] |=> $stable(BRIDGE_CMD))
    else $error("command changed between frames");
  a_off_bridge_a: assert property (BRIDGE_CMD[5:4] == CUR_OFF |=>
    DRIVERS_OFF[0]) else $error("bridge A drivers not off");
  a_off_bridge_b: assert property (BRIDGE_CMD[2:1] == CUR_OFF |=>
    DRIVERS_OFF[1]) else $error("bridge B drivers not off");
  a_ack_one_wait: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("bus request not acknowledged");
  a_ack_no_req: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("acknowledge without request");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");

  // Main scenarios reached
  c_cmd_taken: cover property ($changed(BRIDGE_CMD));
  c_frame_open: cover property ($rose(SDO_OE));
  c_bus_done: cover property (WB_ACK_O);
endmodule

bind ssd_top ssd_chk #(.SETTLE(SETTLE)) u_ssd_chk (
  .CLK(CLK), .RSTN(RSTN), .DEVICE_ACTIVATE_N(DEVICE_ACTIVATE_N),
  .FRAME_SELECT_N(FRAME_SELECT_N), .SCK(SCK), .SDO(SDO),
  .SDO_OE(SDO_OE), .BRIDGE_CMD(BRIDGE_CMD), .DRIVERS_OFF(DRIVERS_OFF),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O)
);

// file: test/ssd_host.sv
// Host model: serial frame master with activation pin.
// Assumes clk is the 20 MHz system clock, used as a time base.
`timescale 1ns/100ps
module ssd_host (
  // Time base
  input  wire logic clk,
  // Serial pins toward the device
  output logic      enn_n,
  output logic      csn_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  // ------------------------------------------------------------
  // Idle levels; serial clock is still outside frames
  // ------------------------------------------------------------
  initial begin
    enn_n = 1'b1;
    csn_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // 30 us setup is 600 cycles; no serial edge may come earlier
  task automatic activate(input logic on);
    @(posedge clk);
    enn_n <= ~on;
    wait_clk(600);
  endtask

  // Half periods of four cycles give the 400 ns link clock
  task automatic frame(input logic [7:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    csn_n <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < nbits; i++) begin
      sdi <= tx[7 - i];
      wait_clk(4);
      sck <= 1'b1;
      wait_clk(4);
      rx = {rx[6:0], sdo};
      sck <= 1'b0;
    end
    wait_clk(8);
    csn_n <= 1'b1;
    sdi <= ~sdi; // Released line must not pass for held data
    wait_clk(8);
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the stepper serial and diagnosis block.
// Assumes ssd_host drives the serial pins and this module the rest.
`timescale 1ns/100ps
module tb_top
  import ssd_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  chop = 2'h0;
  logic [1:0]  trip_p = 2'h0;
  logic [1:0]  short_det = 2'h0;
  logic [1:0]  no_fly = 2'h0;
  logic        src_ovl = 1'b0;
  logic        overtemp = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        enn_n, csn_n, sck, sdi, sdo, sdo_oe;
  logic [7:0]  cmd;
  logic [7:0]  r;
  logic [1:0]  drv_off;
  logic [31:0] q;
  int          fails = 0;
  int          total_checks = 0;

  always #25 clk = ~clk;

  ssd_top #(.SETTLE(SETTLE_SAMPLES)) u_ssd_top (
    .CLK(clk), .RSTN(rstn), .DEVICE_ACTIVATE_N(enn_n),
    .FRAME_SELECT_N(csn_n), .SCK(sck), .SDI(sdi), .SDO(sdo),
    .SDO_OE(sdo_oe), .CHOP_PULSE(chop), .CMP_TRIP(trip_p),
    .SHORT_DET(short_det), .NO_FLYBACK(no_fly), .SRC_OVL(src_ovl),
    .OVERTEMP(overtemp), .BRIDGE_CMD(cmd), .DRIVERS_OFF(drv_off),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf), .WB_DAT_I(wb_wdat),
    .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack)
  );
  ssd_host u_ssd_host (
    .clk(clk), .enn_n(enn_n), .csn_n(csn_n), .sck(sck), .sdi(sdi),
    .sdo(sdo)
  );

  // ------------------------------------------------------------
  // Verdict, compare and bus tasks
  // ------------------------------------------------------------
  task automatic summarize;
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; the wait is bounded so a dead slave ends the run
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 40) begin
      fails++;
      summarize();
    end
  endtask

  // Sensor events are single-cycle pulses on the system clock
  task automatic pulse_chop(input logic [1:0] b, input int n);
    repeat (n) begin
      @(posedge clk);
      chop <= b;
      @(posedge clk);
      chop <= 2'h0;
    end
  endtask

  task automatic trip(input logic s);
    @(posedge clk);
    short_det <= {1'b0, s};
    trip_p <= 2'h1;
    @(posedge clk);
    trip_p <= 2'h0;
  endtask

  // Reply shows the code captured at the end of the previous frame
  task automatic code(input logic ot, input logic ovl, input logic sh,
                      input logic [1:0] exp);
    @(posedge clk);
    overtemp <= ot;
    src_ovl <= ovl;
    if (sh)
      trip(1'b1);
    u_ssd_host.frame(8'h12, 8, r);
    u_ssd_host.frame(8'h12, 8, r);
    chk(r[7:6], exp);
    overtemp <= 1'b0;
    src_ovl <= 1'b0;
  endtask

  // Five frames toggling bridge A polarity from the given setting
  task automatic polar(input logic [7:0] base);
    for (int i = 0; i < 5; i++)
      u_ssd_host.frame(base | (i[0] ? 8'h00 : 8'h08), 8, r);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(cmd, CMD_RST);
    chk(sdo_oe, 1'b0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, 8'hf0, 32'hffff_ffff);
    wb(1'b0, 8'hf0, 32'h0);
    chk(q, 32'h0);
    u_ssd_host.activate(1'b1);
    pulse_chop(2'h3, 3);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[9:8], 2'h0);
    pulse_chop(2'h3, 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[9:8], 2'h3);
    chk(q[14:13], 2'h0);
    u_ssd_host.frame(8'h16, 8, r);
    chk(r, 8'hff);
    chk(drv_off, 2'h2);
    u_ssd_host.frame(8'h12, 8, r);
    chk(r, 8'hd6);
    chk(cmd, 8'h12);
    chk(drv_off, 2'h0);
    u_ssd_host.frame(8'h3c, 0, r);
    u_ssd_host.frame(8'h3c, 5, r);
    chk(cmd, 8'h12);
    wb(1'b0, REG_CMD, 32'h0);
    chk(q[15:0], 16'h0212);
    code(1'b0, 1'b0, 1'b0, FC_NORMAL);
    wb(1'b1, REG_CTRL, 32'h0);
    code(1'b1, 1'b0, 1'b0, FC_NORMAL);
    wb(1'b1, REG_CTRL, 32'h1);
    code(1'b1, 1'b0, 1'b0, FC_OVERTEMP);
    code(1'b0, 1'b1, 1'b0, FC_SOURCE);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[12], 1'b1);
    chk(drv_off, 2'h3);
    u_ssd_host.frame(8'h12, 8, r);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[12], 1'b0);
    chk(drv_off, 2'h0);
    code(1'b0, 1'b0, 1'b1, FC_SINK);
    code(1'b0, 1'b0, 1'b0, FC_SINK);
    repeat (20000) @(posedge clk);
    trip(1'b0);
    code(1'b0, 1'b0, 1'b0, FC_NORMAL);
    no_fly <= 2'h1;
    polar(8'h12);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[13], 1'b1);
    no_fly <= 2'h0;
    pulse_chop(2'h1, 1);
    no_fly <= 2'h1;
    polar(8'h22);
    polar(8'h22);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[13], 1'b0);
    pulse_chop(2'h1, 4);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[13], 1'b1);
    u_ssd_host.activate(1'b0);
    chk(cmd, CMD_RST);
    summarize();
  end
endmodule
